/* dllc_pkg.sv */
// constants, types and register map of the deframer link-layer control
`default_nettype none
package dllc_pkg;
   localparam int LANES = 8;
   localparam int ERR_TYPES = 3;
   localparam int ERR_BDE = 0;
   localparam int ERR_NIT = 1;
   localparam int ERR_UEK = 2;

   // register offsets
   localparam logic [11:0] ADDR_SOFT_CTRL = 12'h475;
   localparam logic [11:0] ADDR_LINK_CTRL1 = 12'h476;
   localparam logic [11:0] ADDR_LINK_CTRL2 = 12'h477;
   localparam logic [11:0] ADDR_K_VALUE = 12'h478;
   localparam logic [11:0] ADDR_ERR_THR = 12'h47c;
   localparam logic [11:0] ADDR_SYNC_MASK = 12'h47d;
   localparam logic [11:0] ADDR_STATUS = 12'h47f;

   // field positions
   localparam int SOFT_RST_BIT = 3;
   localparam int FORCE_SYNC_BIT = 2;
   localparam int SKIP_ALIGN_BIT = 1;
   localparam int CHK_METHOD_BIT = 0;
   localparam int PERP_TEST_BIT = 7;
   localparam int REP_TEST_BIT = 5;
   localparam int QUEUE_MODE_BIT = 4;
   localparam int AUTO_CLR_BIT = 3;
   localparam int STAT_CFG_ERR_BIT = 2;
   localparam int STAT_PAT_ERR_BIT = 3;
   localparam int STAT_SYNC_BIT = 4;

   // reset values and writable bits
   localparam logic [7:0] SOFT_CTRL_RST = 8'h01;
   localparam logic [7:0] SOFT_CTRL_WMASK = 8'h0d;
   localparam logic [7:0] LINK_CTRL1_RST = 8'h14;
   localparam logic [7:0] LINK_CTRL1_WMASK = 8'h1f;
   localparam logic [7:0] LINK_CTRL2_RST = 8'h00;
   localparam logic [7:0] LINK_CTRL2_WMASK = 8'hb8;
   localparam logic [7:0] K_VALUE_RST = 8'h01;
   localparam logic [7:0] ERR_THR_RST = 8'hff;
   localparam logic [7:0] SYNC_MASK_RST = 8'h07;
   localparam logic [7:0] SYNC_MASK_WMASK = 8'h07;

   // alignment-sequence configuration octets
   localparam logic [3:0] CFG_FCHK_IDX = 4'hd;

   // error report pulse on the sync request, in core cycles
   localparam logic [3:0] SYNC_ERR_PULSE_CYC = 4'h4;
   localparam logic [3:0] SYNC_ERR_GAP_CYC = 4'h4;

   // transport test pattern, octet 0 in the low byte
   localparam logic [1:0] TPAT_LAST = 2'h3;
   localparam logic [31:0] TPAT_WORD = 32'h9c5a3cbe;

   typedef enum logic [1:0] {
      ST_WAIT_CGS = 2'b00,
      ST_ILAS = 2'b01,
      ST_DATA = 2'b11,
      ST_TEST = 2'b10
   } dllc_state_t;

   typedef struct packed {
      logic bde;
      logic nit;
      logic uek;
   } dllc_lane_err_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [3:0] idx;
      logic [7:0] octet;
   } dllc_ilas_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dllc_reg_req_t;
endpackage
`default_nettype wire

/* dllc_link_ctrl.sv */
// deframer link-layer control: start-up, checksum, tests, error reporting
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - skip bit set: user data follows code group sync, no alignment sequence
// - skip bit clear: alignment sequence follows code group sync
// - checksum method 0 sums the individual configuration fields
// - checksum method 1 sums the whole configuration octets
// - test mode bit: endless alignment sequence after code group sync
// - repeat test bit: received data checked against transport test pattern
// - queue mode 0: simultaneous errors on several lanes report once
// - queue mode 1: lane errors queued up to 255 pending, signalled one by one
// - auto clear: counter that raised sync request returns to zero
// - auto clear leaves every other error counter untouched
// - soft reset bit is synchronous reset, stops reception while set
// - sync request asks restart; software can force it
module dllc_link_ctrl
   import dllc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire dllc_pkg::dllc_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // receive lanes
   input wire logic cgs_done_i,
   input wire dllc_pkg::dllc_ilas_t ilas_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_octet_i,
   input wire dllc_pkg::dllc_lane_err_t [dllc_pkg::LANES-1:0] lane_err_i,
   // link side
   output logic sync_request_out_n_o,
   output dllc_pkg::dllc_state_t link_state_o
);
   import dllc_pkg::*;

   localparam int HITS = LANES * ERR_TYPES;

   logic [7:0] soft_ctrl_q;
   logic [7:0] link_ctrl1_q;
   logic [7:0] link_ctrl2_q;
   logic [7:0] k_value_q;
   logic [7:0] err_thr_q;
   logic [7:0] sync_mask_q;
   dllc_state_t state_q;
   logic [7:0] chk_sum_q;
   logic cfg_err_q;
   logic pat_err_q;
   logic [1:0] pat_idx_q;
   logic [7:0] queue_q;
   logic [7:0] queue_d;
   logic [3:0] pulse_q;
   logic [7:0] err_cnt_q [LANES][ERR_TYPES];
   logic [HITS-1:0] hit;
   logic any_hit;
   logic [4:0] hit_count;
   logic pulse_start;
   logic pulse_on;
   logic soft_rst;
   logic force_sync;
   logic rx_active;
   logic stat_wr;
   logic [7:0] chk_add;
   logic [7:0] expect_octet;

   // contribution of one configuration octet when summing fields
   function automatic logic [7:0] field_sum(input logic [3:0] idx,
                                            input logic [7:0] o);
      logic [7:0] s;
      s = o;
      unique case (idx)
         4'h1: s = {4'h0, o[7:4]} + {4'h0, o[3:0]};
         4'h2: s = {7'h00, o[6]} + {7'h00, o[5]} + {3'h0, o[4:0]};
         4'h3, 4'ha: s = {7'h00, o[7]} + {3'h0, o[4:0]};
         4'h5: s = {3'h0, o[4:0]};
         4'h7: s = {6'h00, o[7:6]} + {3'h0, o[4:0]};
         4'h8, 4'h9: s = {5'h00, o[7:5]} + {3'h0, o[4:0]};
         default: s = o;
      endcase
      return s;
   endfunction

   function automatic logic [4:0] count_ones(input logic [HITS-1:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < HITS; i++) begin
         n = n + {4'h0, v[i]};
      end
      return n;
   endfunction

   assign soft_rst = soft_ctrl_q[SOFT_RST_BIT];
   assign force_sync = soft_ctrl_q[FORCE_SYNC_BIT];
   assign rx_active = (state_q != ST_WAIT_CGS) && !soft_rst;
   assign stat_wr = reg_req_i.wr && (reg_req_i.addr == ADDR_STATUS);

   // configuration registers, held through soft reset
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_ctrl_q <= SOFT_CTRL_RST;
         link_ctrl1_q <= LINK_CTRL1_RST;
         link_ctrl2_q <= LINK_CTRL2_RST;
         k_value_q <= K_VALUE_RST;
         err_thr_q <= ERR_THR_RST;
         sync_mask_q <= SYNC_MASK_RST;
      end else if (reg_req_i.wr) begin
         unique case (reg_req_i.addr)
            ADDR_SOFT_CTRL: soft_ctrl_q <= reg_req_i.wdata & SOFT_CTRL_WMASK;
            ADDR_LINK_CTRL1:
               link_ctrl1_q <= reg_req_i.wdata & LINK_CTRL1_WMASK;
            ADDR_LINK_CTRL2:
               link_ctrl2_q <= reg_req_i.wdata & LINK_CTRL2_WMASK;
            ADDR_K_VALUE: k_value_q <= reg_req_i.wdata;
            ADDR_ERR_THR: err_thr_q <= reg_req_i.wdata;
            ADDR_SYNC_MASK: sync_mask_q <= reg_req_i.wdata & SYNC_MASK_WMASK;
            default: ;
         endcase
      end
   end

   // register read-back
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            ADDR_SOFT_CTRL: reg_rdata_o <= soft_ctrl_q;
            ADDR_LINK_CTRL1: reg_rdata_o <= link_ctrl1_q;
            ADDR_LINK_CTRL2: reg_rdata_o <= link_ctrl2_q;
            ADDR_K_VALUE: reg_rdata_o <= k_value_q;
            ADDR_ERR_THR: reg_rdata_o <= err_thr_q;
            ADDR_SYNC_MASK: reg_rdata_o <= sync_mask_q;
            ADDR_STATUS: begin
               reg_rdata_o <= 8'h00;
               reg_rdata_o[1:0] <= state_q;
               reg_rdata_o[STAT_CFG_ERR_BIT] <= cfg_err_q;
               reg_rdata_o[STAT_PAT_ERR_BIT] <= pat_err_q;
               reg_rdata_o[STAT_SYNC_BIT] <= !sync_request_out_n_o;
            end
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // link start-up sequence
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_WAIT_CGS;
      end else if (soft_rst || force_sync) begin
         state_q <= ST_WAIT_CGS;
      end else begin
         unique case (state_q)
            ST_WAIT_CGS: begin
               if (cgs_done_i) begin
                  if (link_ctrl2_q[PERP_TEST_BIT]) begin
                     state_q <= ST_TEST;
                  end else if (link_ctrl1_q[SKIP_ALIGN_BIT]) begin
                     state_q <= ST_DATA;
                  end else begin
                     state_q <= ST_ILAS;
                  end
               end
            end
            ST_ILAS: begin
               if (!cgs_done_i) begin
                  state_q <= ST_WAIT_CGS;
               end else if (ilas_i.valid && ilas_i.last) begin
                  state_q <= ST_DATA;
               end
            end
            ST_TEST, ST_DATA: begin
               if (!cgs_done_i) begin
                  state_q <= ST_WAIT_CGS;
               end
            end
         endcase
      end
   end

   assign link_state_o = state_q;

   assign chk_add = link_ctrl1_q[CHK_METHOD_BIT] ? ilas_i.octet
                  : field_sum(ilas_i.idx, ilas_i.octet);

   // checksum over each alignment sequence, also when repeated
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chk_sum_q <= 8'h00;
      end else if (soft_rst) begin
         chk_sum_q <= 8'h00;
      end else if (ilas_i.valid &&
                   (state_q == ST_ILAS || state_q == ST_TEST)) begin
         if (ilas_i.idx == CFG_FCHK_IDX || ilas_i.idx == 4'h0) begin
            chk_sum_q <= (ilas_i.idx == 4'h0) ? chk_add : 8'h00;
         end else begin
            chk_sum_q <= chk_sum_q + chk_add;
         end
      end
   end

   // sticky error flags, write one to clear, set wins
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_err_q <= 1'b0;
      end else if (soft_rst) begin
         cfg_err_q <= 1'b0;
      end else if (ilas_i.valid && ilas_i.idx == CFG_FCHK_IDX &&
                   (state_q == ST_ILAS || state_q == ST_TEST) &&
                   ilas_i.octet != chk_sum_q) begin
         cfg_err_q <= 1'b1;
      end else if (stat_wr && reg_req_i.wdata[STAT_CFG_ERR_BIT]) begin
         cfg_err_q <= 1'b0;
      end
   end

   assign expect_octet = TPAT_WORD[{pat_idx_q, 3'b000} +: 8];

   // repetitive transport pattern check during user data
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pat_idx_q <= 2'h0;
      end else if (state_q != ST_DATA || soft_rst) begin
         pat_idx_q <= 2'h0;
      end else if (rx_valid_i && link_ctrl2_q[REP_TEST_BIT]) begin
         pat_idx_q <= (pat_idx_q == TPAT_LAST) ? 2'h0 : pat_idx_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pat_err_q <= 1'b0;
      end else if (soft_rst) begin
         pat_err_q <= 1'b0;
      end else if (state_q == ST_DATA && rx_valid_i &&
                   link_ctrl2_q[REP_TEST_BIT] &&
                   rx_octet_i != expect_octet) begin
         pat_err_q <= 1'b1;
      end else if (stat_wr && reg_req_i.wdata[STAT_PAT_ERR_BIT]) begin
         pat_err_q <= 1'b0;
      end
   end

   // per-lane, per-type error counters
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      for (genvar t = 0; t < ERR_TYPES; t++) begin : g_type
         logic err;
         logic reach;
         // mask bit order runs opposite to the error order
         assign err = rx_active && lane_err_i[l][ERR_TYPES-1-t];
         assign reach = err && err_cnt_q[l][t] != err_thr_q &&
                        err_cnt_q[l][t] + 8'h01 == err_thr_q;
         assign hit[l*ERR_TYPES+t] = reach && sync_mask_q[ERR_TYPES-1-t];
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               err_cnt_q[l][t] <= 8'h00;
            end else if (soft_rst) begin
               err_cnt_q[l][t] <= 8'h00;
            end else if (hit[l*ERR_TYPES+t] &&
                         link_ctrl2_q[AUTO_CLR_BIT]) begin
               err_cnt_q[l][t] <= 8'h00;
            end else if (err && err_cnt_q[l][t] != err_thr_q) begin
               err_cnt_q[l][t] <= err_cnt_q[l][t] + 8'h01;
            end
         end
      end
   end

   assign any_hit = |hit;
   assign hit_count = count_ones(hit);
   assign pulse_on = pulse_q > SYNC_ERR_GAP_CYC;
   assign pulse_start = (pulse_q == 4'h0) && (queue_q != 8'h00);

   // queue of pending error reports
   always_comb begin
      queue_d = queue_q - {7'h00, pulse_start};
      if (link_ctrl2_q[QUEUE_MODE_BIT]) begin
         if ({1'b0, queue_d} + {4'h0, hit_count} > 9'h0ff) begin
            queue_d = 8'hff;
         end else begin
            queue_d = queue_d + {3'h0, hit_count};
         end
      end else if (any_hit && queue_d == 8'h00) begin
         queue_d = 8'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         queue_q <= 8'h00;
      end else if (soft_rst) begin
         queue_q <= 8'h00;
      end else begin
         queue_q <= queue_d;
      end
   end

   // one report pulse then a gap, back to back while queued
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_q <= 4'h0;
      end else if (soft_rst) begin
         pulse_q <= 4'h0;
      end else if (pulse_start) begin
         pulse_q <= SYNC_ERR_PULSE_CYC + SYNC_ERR_GAP_CYC;
      end else if (pulse_q != 4'h0) begin
         pulse_q <= pulse_q - 4'h1;
      end
   end

   // sync request, active low
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_request_out_n_o <= 1'b0;
      end else begin
         sync_request_out_n_o <= !(soft_rst || force_sync ||
                                   state_q == ST_WAIT_CGS || pulse_on);
      end
   end
endmodule
`default_nettype wire

/* dllc_link_ctrl_monitor.sv */
// port-level assertions for the deframer link-layer control
`timescale 1ns/1ns
`default_nettype none
module dllc_link_ctrl_monitor
   import dllc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire dllc_pkg::dllc_reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   // lane and link side
   input wire logic cgs_done_i,
   input wire dllc_pkg::dllc_ilas_t ilas_i,
   input wire logic sync_request_out_n_o,
   input wire dllc_pkg::dllc_state_t link_state_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   wait_hold_a: assert property (
      link_state_o == ST_WAIT_CGS && !cgs_done_i |=>
      link_state_o == ST_WAIT_CGS)
      else $error("left wait state without code group sync");
   leave_sync_a: assert property (
      $past(link_state_o) == ST_WAIT_CGS && link_state_o != ST_WAIT_CGS
      |=> sync_request_out_n_o)
      else $error("sync request not released after start-up");
   wait_low_a: assert property (
      link_state_o == ST_WAIT_CGS && $past(link_state_o) == ST_WAIT_CGS &&
      $past(link_state_o, 2) == ST_WAIT_CGS |-> !sync_request_out_n_o)
      else $error("sync request not held while waiting");
   ilas_done_a: assert property (
      link_state_o == ST_ILAS && cgs_done_i && ilas_i.valid &&
      ilas_i.last && !reg_req_i.wr && !$past(reg_req_i.wr) |=>
      link_state_o == ST_DATA)
      else $error("no data state after last alignment octet");
   test_loop_a: assert property (
      link_state_o == ST_TEST && cgs_done_i && !reg_req_i.wr &&
      !$past(reg_req_i.wr) |=> link_state_o == ST_TEST)
      else $error("test state left while link up");
   data_hold_a: assert property (
      link_state_o == ST_DATA && cgs_done_i && !reg_req_i.wr &&
      !$past(reg_req_i.wr) |=> link_state_o == ST_DATA)
      else $error("data state left while link up");
   cgs_loss_a: assert property (
      link_state_o != ST_WAIT_CGS && !cgs_done_i |=>
      link_state_o == ST_WAIT_CGS)
      else $error("sync loss did not restart link");
   err_pulse_a: assert property (
      $fell(sync_request_out_n_o) && link_state_o != ST_WAIT_CGS |->
      (!sync_request_out_n_o) [*4] ##1 sync_request_out_n_o)
      else $error("error report pulse not four cycles");
   rdata_hold_a: assert property (
      !reg_req_i.rd |=> $stable(reg_rdata_o))
      else $error("read data changed without read");
endmodule
`default_nettype wire

/* dllc_tx_model.sv */
// behavioural transmitter model driving the deframer lane side
`timescale 1ns/1ns
`default_nettype none
module dllc_tx_model
   import dllc_pkg::*;
(
   // clock and sync request
   input wire logic core_clk_i,
   input wire logic sync_n_i,
   // lane side
   output logic cgs_done_o,
   output dllc_pkg::dllc_ilas_t ilas_o,
   output logic rx_valid_o,
   output logic [7:0] rx_octet_o,
   output dllc_pkg::dllc_lane_err_t [dllc_pkg::LANES-1:0] lane_err_o
);
   initial begin
      cgs_done_o = 1'b0;
      ilas_o = '0;
      rx_valid_o = 1'b0;
      rx_octet_o = 8'h00;
      lane_err_o = '0;
   end
   task automatic link(input logic on);
      @(posedge core_clk_i) #2;
      cgs_done_o = on;
   endtask
   // octet 0 one field, octet 3 two packed fields
   task automatic send_ilas(input logic [7:0] fchk);
      for (int w = 0; w < 20 && !sync_n_i; w++)
         @(posedge core_clk_i) #2;
      for (int i = 0; i < 14; i++) begin
         @(posedge core_clk_i) #2;
         ilas_o.valid = 1'b1;
         ilas_o.idx = i[3:0];
         ilas_o.octet = i == 13 ? fchk : i == 0 ? 8'h12 :
            i == 3 ? 8'h81 : 8'h00;
         ilas_o.last = i == 13;
      end
      @(posedge core_clk_i) #2;
      ilas_o.valid = 1'b0;
      ilas_o.last = 1'b0;
      ilas_o.octet = ~ilas_o.octet;
   endtask
   task automatic send_data(input int n, input logic [7:0] flip);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk_i) #2;
         rx_valid_o = 1'b1;
         rx_octet_o = TPAT_WORD[8*(i%4) +: 8] ^ flip;
      end
      @(posedge core_clk_i) #2;
      rx_valid_o = 1'b0;
      rx_octet_o = ~rx_octet_o;
   endtask
   task automatic err(input logic [LANES-1:0] lanes, input logic [2:0] t);
      @(posedge core_clk_i) #2;
      for (int l = 0; l < LANES; l++)
         lane_err_o[l] = lanes[l] ? t : 3'b000;
      @(posedge core_clk_i) #2;
      lane_err_o = '0;
   endtask
endmodule
`default_nettype wire

/* test_dllc_link_ctrl.sv */
// self-checking bench for the deframer link-layer control
`timescale 1ns/1ns
`default_nettype none
module test_dllc_link_ctrl;
   import dllc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   dllc_reg_req_t req = '0;
   logic [7:0] rdata;
   logic cgs;
   dllc_ilas_t ilas;
   logic rx_valid;
   logic [7:0] rx_octet;
   dllc_lane_err_t [LANES-1:0] lane_err;
   logic sync_n;
   dllc_state_t state;
   int miscompares = 0;
   int total_checks = 0;
   logic [11:0] addrs [7] = '{12'h475, 12'h476, 12'h477, 12'h478, 12'h47c,
      12'h47d, 12'h470};
   logic [7:0] rsts [7] = '{8'h01, 8'h14, 8'h00, 8'h01, 8'hff, 8'h07, 8'h00};
   // field sum 0x14, octet sum 0x93
   logic [7:0] cks [3] = '{8'h14, 8'h93, 8'h93};
   logic [7:0] cerr [3] = '{8'h00, 8'h00, 8'h04};
   always #25 core_clk = ~core_clk;
   dllc_link_ctrl u_dut (
      .core_clk_i(core_clk),
      .rst_n_i(rst_n),
      .reg_req_i(req),
      .reg_rdata_o(rdata),
      .cgs_done_i(cgs),
      .ilas_i(ilas),
      .rx_valid_i(rx_valid),
      .rx_octet_i(rx_octet),
      .lane_err_i(lane_err),
      .sync_request_out_n_o(sync_n),
      .link_state_o(state)
   );
   dllc_tx_model u_tx (
      .core_clk_i(core_clk),
      .sync_n_i(sync_n),
      .cgs_done_o(cgs),
      .ilas_o(ilas),
      .rx_valid_o(rx_valid),
      .rx_octet_o(rx_octet),
      .lane_err_o(lane_err)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk) #2;
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(posedge core_clk) #2;
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge core_clk) #2;
      req.rd = 1'b1;
      req.addr = a;
      @(posedge core_clk) #2;
      req.rd = 1'b0;
      check(rdata & m, e);
   endtask
   // reconfigure under soft reset, bring the link up
   task automatic start(input logic [7:0] c1, input logic [7:0] c2,
      input logic [7:0] thr, input dllc_state_t es, input logic [7:0] fchk);
      u_tx.link(1'b0);
      wr(ADDR_SOFT_CTRL, 8'h09);
      wr(ADDR_LINK_CTRL1, c1);
      wr(ADDR_LINK_CTRL2, c2);
      wr(ADDR_ERR_THR, thr);
      wr(ADDR_SOFT_CTRL, 8'h01);
      u_tx.link(1'b1);
      for (int i = 0; i < 10 && state === ST_WAIT_CGS; i++)
         @(posedge core_clk) #2;
      check({6'h00, state}, {6'h00, es});
      if (es == ST_ILAS) begin
         u_tx.send_ilas(fchk);
         repeat (2) @(posedge core_clk) #2;
         check({6'h00, state}, {6'h00, ST_DATA});
      end
   endtask
   task automatic pulses(input logic [7:0] exp);
      logic prev;
      logic [7:0] n;
      prev = sync_n;
      n = 8'h00;
      repeat (40) begin
         @(posedge core_clk) #2;
         if (prev && !sync_n)
            n++;
         prev = sync_n;
      end
      check(n, exp);
   endtask
   initial begin
      #2000000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
      foreach (addrs[i]) rd(addrs[i], 8'hff, rsts[i]);
      wr(ADDR_SOFT_CTRL, 8'h09);
      wr(ADDR_LINK_CTRL2, 8'hff);
      wr(ADDR_SYNC_MASK, 8'hff);
      wr(12'h470, 8'hff);
      rd(ADDR_LINK_CTRL2, 8'hff, 8'hb8);
      rd(ADDR_SYNC_MASK, 8'hff, 8'h07);
      rd(12'h470, 8'hff, 8'h00);
      for (int i = 0; i < 3; i++) begin
         start({7'h0a, i[0]}, 8'h00, 8'hff, ST_ILAS, cks[i]);
         rd(ADDR_STATUS, 8'h04, cerr[i]);
      end
      wr(ADDR_STATUS, 8'h04);
      rd(ADDR_STATUS, 8'h04, 8'h00);
      start(8'h16, 8'h00, 8'hff, ST_DATA, 8'h00);
      start(8'h14, 8'h80, 8'hff, ST_TEST, 8'h00);
      u_tx.send_ilas(8'h14);
      u_tx.send_ilas(8'h14);
      check({6'h00, state}, {6'h00, ST_TEST});
      rd(ADDR_STATUS, 8'h04, 8'h00);
      start(8'h14, 8'h20, 8'hff, ST_ILAS, 8'h14);
      u_tx.send_data(8, 8'h00);
      rd(ADDR_STATUS, 8'h08, 8'h00);
      u_tx.send_data(8, 8'hff);
      rd(ADDR_STATUS, 8'h08, 8'h08);
      wr(ADDR_STATUS, 8'h08);
      rd(ADDR_STATUS, 8'h08, 8'h00);
      start(8'h14, 8'h00, 8'h01, ST_ILAS, 8'h14);
      u_tx.err(8'h03, 3'b111);
      pulses(8'h01);
      start(8'h14, 8'h10, 8'h01, ST_ILAS, 8'h14);
      u_tx.err(8'h03, 3'b100);
      pulses(8'h02);
      start(8'h14, 8'h08, 8'h02, ST_ILAS, 8'h14);
      u_tx.err(8'h01, 3'b100);
      u_tx.err(8'h02, 3'b100);
      u_tx.err(8'h01, 3'b100);
      pulses(8'h01);
      u_tx.err(8'h02, 3'b100);
      pulses(8'h01);
      u_tx.err(8'h01, 3'b100);
      u_tx.err(8'h01, 3'b100);
      pulses(8'h01);
      wr(ADDR_SOFT_CTRL, 8'h05);
      repeat (3) @(posedge core_clk) #2;
      check({6'h00, state}, 8'h00);
      check({7'h00, sync_n}, 8'h00);
      wr(ADDR_SOFT_CTRL, 8'h01);
      wr(ADDR_SOFT_CTRL, 8'h09);
      repeat (3) @(posedge core_clk) #2;
      check({6'h00, state}, 8'h00);
      check({7'h00, sync_n}, 8'h00);
      complete_run();
   end
endmodule
bind dllc_link_ctrl dllc_link_ctrl_monitor u_mon (
   .core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i),
   .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o),
   .cgs_done_i(cgs_done_i),
   .ilas_i(ilas_i),
   .sync_request_out_n_o(sync_request_out_n_o),
   .link_state_o(link_state_o)
);
`default_nettype wire
